// ---- verilog/port_phy_map.vh ----
/*
   constants for the per-port phy control/status bank: register offsets,
   field positions, reset values, mode codes, timing and management frame.
   assumes inclusion by the bank only.
*/
`ifndef PORT_PHY_MAP_VH
`define PORT_PHY_MAP_VH

// register map: ports 2..5 at high nibble 2..5
`define PORT_NIB_FIRST   4'h2
`define PORT_NIB_LAST    4'h5
`define OFS_STATUS1_LOW  4'he
`define OFS_CTRL_STAT    4'hf
`define OFS_P2_CTRL_STAT 8'h2f
`define OFS_P3_CTRL_STAT 8'h3f
`define OFS_P4_CTRL_STAT 8'h4f
`define OFS_P5_CTRL_STAT 8'h5f

// control/status byte fields
`define BIT_LOOPBACK     7
`define BIT_RESERVED     6
`define BIT_ISOLATE      5
`define BIT_SOFT_RESET   4
`define BIT_FORCE_LINK   3
`define BIT_PARTNER_10HD 0
`define CTRL_RESET       1'b0

// operating mode codes
`define MODE_AUTONEG     3'h1
`define MODE_10_HALF     3'h2
`define MODE_100_HALF    3'h3
`define MODE_10_FULL     3'h5
`define MODE_100_FULL    3'h6

// timing
`define CLK_NS           40
`define SOFT_RESET_NS    640
`define SOFT_RESET_CYC   ((`SOFT_RESET_NS + `CLK_NS - 1) / `CLK_NS)
`define SOFT_RESET_LAST  5'd15

// management frame
`define MIIM_PREAMBLE    6'd32
`define MIIM_OP_READ     2'h2
`define MIIM_OP_WRITE    2'h1
`define MIIM_REG_STATUS  5'h1e
`define MIIM_REG_CTRL    5'h1f
`define MIIM_HDR_LAST    4'd12
`define MIIM_DATA_LAST   4'd15

`endif

// ---- verilog/sync_agree.v ----
/*
   three-flop synchroniser for pin inputs; a new value is taken once the
   second and third stage agree.
   assumes mclk, synchronous active-low reset and a clock enable.
*/
`timescale 1ns/10ps

module sync_agree #(
   parameter W = 1
) (
   // clock and reset
   input  wire         mclk,
   input  wire         reset_n,
   input  wire         ce,
   // pin side
   input  wire [W-1:0] d,
   // synchronised value
   output reg  [W-1:0] q
);

reg [W-1:0] s1_q;
reg [W-1:0] s2_q;
reg [W-1:0] s3_q;

////////////////////////////////////////////////////////////////////////////////

// first stage feeds the second and nothing else
always @(posedge mclk) begin
   if (!reset_n) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      q    <= {W{1'b0}};
   end else if (ce) begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
         q <= s3_q;
      end
   end
end

endmodule

// ---- verilog/port_phy_ctrl.v ----
/*
   per-port phy control and status bank for ports 2..5: control/status
   byte, partner status bit, register port and mirrored mdc/mdio access.
   assumes phy-side inputs are asynchronous pins, mdc well below mclk/8,
   and a single 25 MHz mclk.
*/
`timescale 1ns/10ps
`include "port_phy_map.vh"

module port_phy_ctrl (
   // clock, reset, enable
   input  wire        mclk,
   input  wire        reset_n,
   input  wire        ce,
   // register port
   input  wire [7:0]  reg_addr,
   input  wire        reg_wr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata_q,
   // management pins
   input  wire        mdc,
   input  wire        mdio_in,
   output reg         mdio_out_q,
   output reg         mdio_oe_q,
   // phy status pins, index 0 is port 2
   input  wire [3:0]  phy_partner_10hd,
   input  wire [11:0] phy_mode,
   // phy controls
   output reg  [3:0]  phy_loopback_q,
   output reg  [3:0]  phy_isolate_q,
   output reg  [3:0]  phy_soft_reset_q,
   output reg  [3:0]  phy_force_link_q
);

localparam S_PRE  = 2'b00;
localparam S_HDR  = 2'b01;
localparam S_TA   = 2'b10;
localparam S_DATA = 2'b11;

integer p;

reg  [3:0]  partner_q;
reg  [2:0]  mode_q [0:3];
reg  [4:0]  srst_cnt_q [0:3];

reg  [1:0]  st_q;
reg  [5:0]  ones_q;
reg  [3:0]  cnt_q;
reg  [11:0] hdr_q;
reg  [15:0] sh_q;
reg         rd_op_q;
reg         hit_q;
reg         mdc_prev_q;
reg         mi_we_q;
reg  [1:0]  mi_port_q;
reg  [7:0]  mi_wdata_q;

wire [1:0]  mi_sync;
wire [15:0] phy_sync;
wire        mdc_s;
wire        mdio_s;
wire        mdc_rise;

wire        reg_port_ok;
wire [1:0]  reg_port;
wire [12:0] hdr_full;
wire        hdr_ok;
wire [1:0]  hdr_port;
wire [7:0]  cs_byte [0:3];

reg  [3:0]  wr_en;
reg  [7:0]  wr_byte;
reg  [15:0] mi_rdata;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

sync_agree #(
   .W (2)
) u_sync_mi (
   .mclk    (mclk),
   .reset_n (reset_n),
   .ce      (ce),
   .d       ({mdc, mdio_in}),
   .q       (mi_sync)
);

genvar g;
generate
   for (g = 0; g < 4; g = g + 1) begin : gen_port
      // one vector per port so mode bits are taken together, never torn
      sync_agree #(
         .W (4)
      ) u_sync_phy (
         .mclk    (mclk),
         .reset_n (reset_n),
         .ce      (ce),
         .d       ({phy_partner_10hd[g], phy_mode[3*g+2:3*g]}),
         .q       (phy_sync[4*g+3:4*g])
      );
      // reserved bit reads 0
      assign cs_byte[g] = {phy_loopback_q[g], 1'b0, phy_isolate_q[g],
                           phy_soft_reset_q[g], phy_force_link_q[g], mode_q[g]};
   end
endgenerate

assign mdc_s    = mi_sync[1];
assign mdio_s   = mi_sync[0];
assign mdc_rise = mdc_s & ~mdc_prev_q;

////////////////////////////////////////////////////////////////////////////////
// address decode

assign reg_port_ok = (reg_addr[7:4] >= `PORT_NIB_FIRST) &&
                     (reg_addr[7:4] <= `PORT_NIB_LAST);
// nibbles 2..5 wrap onto port index 0..3
assign reg_port    = reg_addr[5:4] - 2'b10;

assign hdr_full = {hdr_q, mdio_s};
assign hdr_port = hdr_full[6:5] - 2'b10;
assign hdr_ok   = hdr_full[12] &&
                  ((hdr_full[11:10] == `MIIM_OP_READ) ||
                   (hdr_full[11:10] == `MIIM_OP_WRITE)) &&
                  (hdr_full[9:5] >= {1'b0, `PORT_NIB_FIRST}) &&
                  (hdr_full[9:5] <= {1'b0, `PORT_NIB_LAST}) &&
                  ((hdr_full[4:0] == `MIIM_REG_STATUS) ||
                   (hdr_full[4:0] == `MIIM_REG_CTRL));

// register port wins a same-cycle collision; the mdio write is dropped
always @* begin
   wr_en   = 4'h0;
   wr_byte = reg_wdata;
   if (reg_wr && reg_port_ok && (reg_addr[3:0] == `OFS_CTRL_STAT)) begin
      wr_en[reg_port] = 1'b1;
   end else if (mi_we_q) begin
      wr_en[mi_port_q] = 1'b1;
      wr_byte          = mi_wdata_q;
   end
end

always @* begin
   mi_rdata = 16'h0000;
   if (hdr_full[4:0] == `MIIM_REG_CTRL) begin
      mi_rdata[7:0] = cs_byte[hdr_port];
   end else begin
      mi_rdata[0] = partner_q[hdr_port];
   end
end

////////////////////////////////////////////////////////////////////////////////
// control/status byte per port

always @(posedge mclk) begin
   if (!reset_n) begin
      phy_loopback_q   <= {4{`CTRL_RESET}};
      phy_isolate_q    <= {4{`CTRL_RESET}};
      phy_soft_reset_q <= {4{`CTRL_RESET}};
      phy_force_link_q <= {4{`CTRL_RESET}};
      partner_q        <= 4'h0;
      for (p = 0; p < 4; p = p + 1) begin
         mode_q[p]     <= `MODE_AUTONEG;
         srst_cnt_q[p] <= 5'h00;
      end
   end else if (ce) begin
      for (p = 0; p < 4; p = p + 1) begin
         partner_q[p] <= phy_sync[4*p+3];
         // mode reads autonegotiating while the phy is held in reset
         if (phy_soft_reset_q[p]) begin
            mode_q[p] <= `MODE_AUTONEG;
         end else begin
            case (phy_sync[4*p+2 -: 3])
               `MODE_10_HALF  : mode_q[p] <= `MODE_10_HALF;
               `MODE_100_HALF : mode_q[p] <= `MODE_100_HALF;
               `MODE_10_FULL  : mode_q[p] <= `MODE_10_FULL;
               `MODE_100_FULL : mode_q[p] <= `MODE_100_FULL;
               default        : mode_q[p] <= `MODE_AUTONEG;
            endcase
         end
         if (wr_en[p]) begin
            phy_loopback_q[p]   <= wr_byte[`BIT_LOOPBACK];
            phy_isolate_q[p]    <= wr_byte[`BIT_ISOLATE];
            phy_force_link_q[p] <= wr_byte[`BIT_FORCE_LINK];
         end
         // a new write of 1 restarts the reset, so set beats self-clear
         if (wr_en[p] && wr_byte[`BIT_SOFT_RESET]) begin
            phy_soft_reset_q[p] <= 1'b1;
            srst_cnt_q[p]       <= 5'h00;
            mode_q[p]           <= `MODE_AUTONEG;
         end else if (phy_soft_reset_q[p]) begin
            if (srst_cnt_q[p] == `SOFT_RESET_LAST) begin
               phy_soft_reset_q[p] <= 1'b0;
            end else begin
               srst_cnt_q[p] <= srst_cnt_q[p] + 5'h01;
            end
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// register port read, data one cycle after the strobe

always @(posedge mclk) begin
   if (!reset_n) begin
      reg_rdata_q <= 8'h00;
   end else if (ce) begin
      if (reg_rd) begin
         if (reg_port_ok && (reg_addr[3:0] == `OFS_CTRL_STAT)) begin
            reg_rdata_q <= cs_byte[reg_port];
         end else if (reg_port_ok && (reg_addr[3:0] == `OFS_STATUS1_LOW)) begin
            reg_rdata_q <= {7'h00, partner_q[reg_port]};
         end else begin
            reg_rdata_q <= 8'h00;
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// mdc/mdio management slave

always @(posedge mclk) begin
   if (!reset_n) begin
      st_q       <= S_PRE;
      ones_q     <= 6'h00;
      cnt_q      <= 4'h0;
      hdr_q      <= 12'h000;
      sh_q       <= 16'h0000;
      rd_op_q    <= 1'b0;
      hit_q      <= 1'b0;
      mdc_prev_q <= 1'b0;
      mdio_out_q <= 1'b0;
      mdio_oe_q  <= 1'b0;
      mi_we_q    <= 1'b0;
      mi_port_q  <= 2'h0;
      mi_wdata_q <= 8'h00;
   end else if (ce) begin
      mdc_prev_q <= mdc_s;
      mi_we_q    <= 1'b0;
      if (mdc_rise) begin
         case (st_q)
            S_PRE : begin
               if (mdio_s) begin
                  if (ones_q != `MIIM_PREAMBLE) begin
                     ones_q <= ones_q + 6'h01;
                  end
               end else if (ones_q == `MIIM_PREAMBLE) begin
                  st_q  <= S_HDR;
                  cnt_q <= 4'h0;
               end else begin
                  ones_q <= 6'h00;
               end
            end
            S_HDR : begin
               hdr_q <= hdr_full[11:0];
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == `MIIM_HDR_LAST) begin
                  // foreign address: stay off the line until a new preamble
                  hit_q     <= hdr_ok;
                  rd_op_q   <= (hdr_full[11:10] == `MIIM_OP_READ);
                  mi_port_q <= hdr_port;
                  sh_q      <= mi_rdata;
                  cnt_q     <= 4'h0;
                  ones_q    <= 6'h00;
                  st_q      <= hdr_ok ? S_TA : S_PRE;
               end
            end
            S_TA : begin
               cnt_q <= 4'h1;
               if (rd_op_q) begin
                  mdio_oe_q <= 1'b1;
                  if (cnt_q == 4'h0) begin
                     mdio_out_q <= 1'b0;
                  end else begin
                     mdio_out_q <= sh_q[15];
                     sh_q       <= {sh_q[14:0], 1'b0};
                  end
               end
               if (cnt_q != 4'h0) begin
                  st_q  <= S_DATA;
                  cnt_q <= 4'h0;
               end
            end
            default : begin
               cnt_q <= cnt_q + 4'h1;
               if (rd_op_q) begin
                  mdio_out_q <= sh_q[15];
                  sh_q       <= {sh_q[14:0], 1'b0};
               end else begin
                  sh_q <= {sh_q[14:0], mdio_s};
               end
               if (cnt_q == `MIIM_DATA_LAST) begin
                  mdio_oe_q  <= 1'b0;
                  mdio_out_q <= 1'b0;
                  st_q       <= S_PRE;
                  ones_q     <= 6'h00;
                  // status register is read-only over mdio as well
                  if (!rd_op_q && hit_q && (hdr_q[4:0] == `MIIM_REG_CTRL)) begin
                     mi_we_q    <= 1'b1;
                     mi_wdata_q <= {sh_q[6:0], mdio_s};
                  end
               end
            end
         endcase
      end
   end
end

endmodule

// ---- testbench/port_phy_ctrl_chk.sv ----
/*
   port-level assertions for the phy control/status bank.
   assumes one mclk domain and binding onto port_phy_ctrl.
*/
`timescale 1ns/10ps

module port_phy_ctrl_chk (
   // clock and reset
   input wire        mclk,
   input wire        reset_n,
   input wire        ce,
   // register port
   input wire [7:0]  reg_addr,
   input wire        reg_wr,
   input wire [7:0]  reg_wdata,
   input wire        reg_rd,
   input wire [7:0]  reg_rdata_q,
   // management pins
   input wire        mdc,
   input wire        mdio_in,
   input wire        mdio_out_q,
   input wire        mdio_oe_q,
   // phy side
   input wire [3:0]  phy_partner_10hd,
   input wire [11:0] phy_mode,
   input wire [3:0]  phy_loopback_q,
   input wire [3:0]  phy_isolate_q,
   input wire [3:0]  phy_soft_reset_q,
   input wire [3:0]  phy_force_link_q
);
default clocking @(posedge mclk); endclocking
default disable iff (!reset_n);
wire wr_ok = ce && reg_wr;
wire rd_ok = ce && reg_rd;
////////////////////////////////////////////////////////////////////////////////
property p_loop;
   wr_ok && reg_addr == 8'h2f |=> phy_loopback_q[0] == $past(reg_wdata[7]);
endproperty
a_loop: assert property (p_loop) else $error("loopback not taken");
property p_port4;
   wr_ok && reg_addr == 8'h4f |=> phy_loopback_q[2] == $past(reg_wdata[7]);
endproperty
a_port4: assert property (p_port4) else $error("port 4 loopback wrong");
property p_iso;
   wr_ok && reg_addr == 8'h3f |=> phy_isolate_q[1] == $past(reg_wdata[5]);
endproperty
a_iso: assert property (p_iso) else $error("isolate not taken");
property p_force;
   wr_ok && reg_addr == 8'h5f |=> phy_force_link_q[3] == $past(reg_wdata[3]);
endproperty
a_force: assert property (p_force) else $error("force link not taken");
property p_srst_set;
   wr_ok && reg_addr == 8'h2f && reg_wdata[4] |=> phy_soft_reset_q[0];
endproperty
a_srst_set: assert property (p_srst_set) else $error("soft reset not set");
// a rewrite in mid-count restarts it, so the bench never does that
property p_srst_len;
   $rose(phy_soft_reset_q[0]) |->
      phy_soft_reset_q[0][*8] ##1 phy_soft_reset_q[0][*8] ##1 !phy_soft_reset_q[0];
endproperty
a_srst_len: assert property (p_srst_len) else $error("soft reset length");
property p_rd_srst;
   phy_soft_reset_q[0] && rd_ok && reg_addr == 8'h2f |=>
      reg_rdata_q[4] && reg_rdata_q[2:0] == 3'h1;
endproperty
a_rd_srst: assert property (p_rd_srst) else $error("mode during reset");
property p_unmapped;
   rd_ok && reg_addr == 8'h6f |=> reg_rdata_q == 8'h00;
endproperty
a_unmapped: assert property (p_unmapped) else $error("unmapped read");
property p_ta;
   $rose(mdio_oe_q) |-> (mdio_oe_q && !mdio_out_q)[*8];
endproperty
a_ta: assert property (p_ta) else $error("turnaround bit wrong");
c_srst: cover property ($rose(phy_soft_reset_q[0]));
c_mdio: cover property ($rose(mdio_oe_q));
c_unmapped: cover property (rd_ok && reg_addr == 8'h6f);
endmodule

bind port_phy_ctrl port_phy_ctrl_chk chk (.mclk(mclk), .reset_n(reset_n), .ce(ce),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
   .reg_rdata_q(reg_rdata_q), .mdc(mdc), .mdio_in(mdio_in), .mdio_out_q(mdio_out_q),
   .mdio_oe_q(mdio_oe_q), .phy_partner_10hd(phy_partner_10hd), .phy_mode(phy_mode),
   .phy_loopback_q(phy_loopback_q), .phy_isolate_q(phy_isolate_q),
   .phy_soft_reset_q(phy_soft_reset_q), .phy_force_link_q(phy_force_link_q));

// ---- testbench/miim_master.sv ----
/*
   management master model: one clause-22 frame per call.
   assumes a pull-up on the shared data wire and mclk for pacing.
*/
`timescale 1ns/10ps

module miim_master (
   // pacing clock
   input wire mclk,
   // resolved data wire
   input wire mdio,
   // master pins
   output reg mdc,
   output reg mdio_o,
   output reg mdio_en
);
initial begin
   mdc = 1'b0;
   mdio_o = 1'b1;
   mdio_en = 1'b0;
end
////////////////////////////////////////////////////////////////////////////////
// half periods of 10 (high) and 11 (low) mclk keep well above the 8-cycle minimum
task frame(input [1:0] op, input [4:0] phy, input [4:0] rg, input [15:0] wd,
           output [15:0] rd);
   reg [63:0] f;
   reg [63:0] s;
   integer    i;
   begin
      f = {32'hffff_ffff, 2'b01, op, phy, rg, 2'b10, wd};
      for (i = 63; i >= 0; i--) begin
         @(posedge mclk);
         mdio_o <= f[i];
         mdio_en <= i > 17 || op == 2'b01;
         repeat (10) @(posedge mclk);
         mdc <= 1'b1;
         s = {s[62:0], mdio};
         repeat (10) @(posedge mclk);
         mdc <= 1'b0;
      end
      @(posedge mclk);
      mdio_en <= 1'b0;
      rd = s[15:0];
   end
endtask
endmodule

// ---- testbench/port_phy_ctrl_test.sv ----
/*
   self-checking bench for port_phy_ctrl.
   assumes the miim_master partner and the bound checker.
*/
`timescale 1ns/10ps
`define chk(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
   $display("ERROR %0t got %h exp %h", $time, a, e); end end

module port_phy_ctrl_test;
reg         mclk = 1'b0;
reg         reset_n = 1'b0;
reg         ce = 1'b1;
reg         reg_wr = 1'b0;
reg         reg_rd = 1'b0;
reg  [7:0]  reg_addr = 8'h00;
reg  [7:0]  reg_wdata = 8'h00;
reg  [3:0]  partner = 4'h5;
reg  [11:0] phy_mode = 12'h249;
wire [7:0]  reg_rdata_q;
wire        mdc, mdio_out_q, mdio_oe_q, m_o, m_en;
wire [3:0]  lb, iso, srst, fl;
// released wire floats to the pull-up level
wire        mdio = mdio_oe_q ? mdio_out_q : m_en ? m_o : 1'b1;
integer     miscompares = 0;
integer     cmp_count = 0;
integer     i, n;
reg  [7:0]  a, v;
reg  [15:0] w;
always #20 mclk = ~mclk;

port_phy_ctrl uut (.mclk(mclk), .reset_n(reset_n), .ce(ce), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
   .mdc(mdc), .mdio_in(mdio), .mdio_out_q(mdio_out_q), .mdio_oe_q(mdio_oe_q),
   .phy_partner_10hd(partner), .phy_mode(phy_mode), .phy_loopback_q(lb),
   .phy_isolate_q(iso), .phy_soft_reset_q(srst), .phy_force_link_q(fl));
miim_master m (.mclk(mclk), .mdio(mdio), .mdc(mdc), .mdio_o(m_o), .mdio_en(m_en));
////////////////////////////////////////////////////////////////////////////////
task wr(input [7:0] ad, input [7:0] d); begin
   @(posedge mclk);
   reg_addr <= ad;
   reg_wdata <= d;
   reg_wr <= 1'b1;
   @(posedge mclk);
   reg_wr <= 1'b0;
end endtask
task rd(input [7:0] ad, output [7:0] d); begin
   @(posedge mclk);
   reg_addr <= ad;
   reg_rd <= 1'b1;
   @(posedge mclk);
   reg_rd <= 1'b0;
   #1 d = reg_rdata_q;
end endtask
task stop_test; begin
   if (miscompares == 0 && cmp_count > 0) begin
      $display("verification passed");
   end else begin
      $display("verification failed");
   end
   $finish;
end endtask
////////////////////////////////////////////////////////////////////////////////
task t_reset; begin
   `chk({lb, iso, srst, fl}, 16'h0000)
   for (i = 0; i < 4; i++) begin
      rd({i[3:0] + 4'h2, 4'hf}, v);
      `chk(v, 8'h01)
   end
end endtask
task t_ctrl; begin
   @(posedge mclk) phy_mode <= 12'hd5a;
   repeat (6) @(posedge mclk);
   for (i = 0; i < 4; i++) begin
      a = {i[3:0] + 4'h2, 4'hf};
      rd(a, v);
      wr(a, v & 8'h40 | 8'hab);
      #1 `chk({lb[i], iso[i], srst[i], fl[i]}, 4'hd)
      rd(a, v);
      `chk(v, {5'h15, phy_mode[3*i+:3]})
      wr(a, 8'h00);
      #1 `chk({lb[i], iso[i], fl[i]}, 3'h0)
   end
   rd(8'h6f, v);
   `chk(v, 8'h00)
   wr(8'h1f, 8'hff);
   #1 `chk({lb, iso, fl}, 12'h000)
   // enable low must swallow a write
   @(posedge mclk) ce <= 1'b0;
   wr(8'h3f, 8'hff);
   #1 `chk({lb, iso, srst, fl}, 16'h0000)
   @(posedge mclk) ce <= 1'b1;
end endtask
task t_mode; begin
   for (i = 0; i < 8; i++) begin
      @(posedge mclk) phy_mode[11:9] <= i[2:0];
      repeat (6) @(posedge mclk);
      rd(8'h5f, v);
      `chk(v[2:0], (i == 0 || i == 4 || i == 7) ? 3'h1 : i[2:0])
   end
   @(posedge mclk) phy_mode[11:9] <= 3'h6;
   for (i = 0; i < 2; i++) begin
      @(posedge mclk) partner <= i[0] ? 4'ha : 4'h5;
      wr(8'h2e, 8'hff);
      repeat (6) @(posedge mclk);
      rd(8'h2e, v);
      `chk(v, {7'h00, !i[0]})
   end
end endtask
task t_srst; begin
   wr(8'h2f, 8'h10);
   n = 0;
   #1 while (srst[0] === 1'b1 && n < 40) begin
      @(posedge mclk);
      #1 n++;
   end
   `chk(n, 16)
   wr(8'h2f, 8'h10);
   rd(8'h2f, v);
   `chk(v, 8'h11)
   repeat (20) @(posedge mclk);
   rd(8'h2f, v);
   `chk(v, 8'h02)
end endtask
task t_miim; begin
   m.frame(2'b01, 5'h04, 5'h1f, 16'h00ab, w);
   #1 `chk({lb[2], iso[2], fl[2]}, 3'h7)
   rd(8'h4f, v);
   `chk(v, 8'had)
   m.frame(2'b10, 5'h04, 5'h1f, 16'h0000, w);
   `chk(w, 16'h00ad)
   m.frame(2'b10, 5'h02, 5'h1e, 16'h0000, w);
   `chk(w, {15'h0000, partner[0]})
   m.frame(2'b10, 5'h01, 5'h1f, 16'h0000, w);
   `chk(w, 16'hffff)
end endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
   #1000000;
   miscompares++;
   stop_test;
end
initial begin
   repeat (12) @(posedge mclk);
   reset_n <= 1'b1;
   @(posedge mclk);
   t_reset;
   t_ctrl;
   t_mode;
   t_srst;
   t_miim;
   stop_test;
end
endmodule
